// ---- sfpi_pin_interface.v ----
//
// Contract
// (R01) host uses clock mode 0 or 3
// (R02) deselected: all data outputs released
// (R03) deselected and idle core: standby power
// (R04) select low: enabled, active power
// (R05) host makes select fall before first instruction
// (R06) sample input bits on clock rise
// (R07) change output bits on clock fall
// (R08) single-bit input carried on io0 only
// (R09) dual/quad read turns io0 into output
// (R10) io0 ignored while deselected
// (R11) dual read drives io1 with io0
// (R12) io1 released whenever deselected
// (R13) write-protect low locks status writes
// (R14) protect pin plus range bits lock array
// (R15) quad enable disables protect, io2 data
// (R16) array is 32768 pages of 256 bytes
// (R17) page program takes 1 to 256 bytes
// (R18) erase in 4K, 32K, 64K, chip units
// (R19) pause ignores clock, io0; releases io1
// (R20) host pauses only selected, clock low
// (R21) pause leaves internal cycles running
// (R22) bytes shift most-significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "sfpi_consts.vh"

module sfpi_pin_interface #(
    parameter FIFO_DEPTH = `SFPI_FIFO_DEPTH,
    parameter FIFO_AW = 2
) (
    input wire i_clock,
    input wire i_rst_n,
    // serial pins
    input wire i_select_n,
    input wire i_sck,
    input wire i_io0,
    output reg o_io0,
    output wire o_io0_oe,
    input wire i_io1,
    output reg o_io1,
    output wire o_io1_oe,
    input wire i_io2,
    output reg o_io2,
    output wire o_io2_oe,
    input wire i_io3,
    output reg o_io3,
    output wire o_io3_oe,
    // core command side
    input wire [1:0] i_in_width,
    input wire [1:0] i_out_width,
    input wire i_out_phase,
    input wire i_tx_valid,
    output wire o_tx_ready,
    input wire [7:0] i_tx_data,
    output wire o_rx_valid,
    input wire i_rx_ready,
    output wire [7:0] o_rx_data,
    output reg o_rx_overrun,
    output reg o_tx_underrun,
    // power and state
    input wire i_busy,
    output reg o_active,
    output reg o_standby,
    output reg o_armed,
    output reg o_paused,
    output reg o_frame_start,
    output reg o_frame_end,
    output reg [`SFPI_FRAME_CNT_BITS-1:0] o_frame_bytes,
    output reg o_page_full,
    // protection
    input wire i_quad_enable_bit,
    input wire i_status_protect_bit,
    input wire i_small_region_bit,
    input wire i_top_bottom_select,
    input wire [2:0] i_protect_range_bits,
    input wire [`SFPI_ADDR_BITS-1:0] i_probe_addr,
    input wire [1:0] i_erase_kind,
    output reg o_status_write_locked,
    output reg o_addr_in_range,
    output reg o_addr_hw_locked,
    output reg [`SFPI_ADDR_BITS-1:0] o_erase_base
);

    // ----------------------------------------
    // pin synchronisers and edge finders
    // ----------------------------------------
    reg [5:0] meta_reg;
    reg [5:0] sync_reg;
    reg sck_last_reg;
    reg sel_last_reg;
    wire sel_n_s;
    wire sck_s;
    wire [3:0] io_s;
    wire selected;
    wire sck_rise;
    wire sck_fall;
    wire sel_fall;
    wire sel_rise;

    // the first stage is read only by the second stage
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_reg <= 6'h3F;
            sync_reg <= 6'h3F;
            sck_last_reg <= 1'b0;
            sel_last_reg <= 1'b1;
        end else begin
            meta_reg <= {i_select_n, i_sck, i_io3, i_io2, i_io1, i_io0};
            sync_reg <= meta_reg;
            sck_last_reg <= sck_s;
            sel_last_reg <= sel_n_s;
        end
    end

    assign sel_n_s = sync_reg[5];
    assign sck_s = sync_reg[4];
    assign io_s = sync_reg[3:0];
    assign selected = (sel_n_s == `SFPI_SEL_ACTIVE) && o_armed;
    assign sel_fall = sel_last_reg && !sel_n_s;
    assign sel_rise = !sel_last_reg && sel_n_s;

    // ----------------------------------------
    // pause and edge qualification
    // ----------------------------------------
    // io3 is only a pause pin while the quad lanes are off
    wire pause_now;
    assign pause_now = selected && !i_quad_enable_bit && (io_s[3] == `SFPI_PAUSE_ACTIVE); // [R19]
    assign sck_rise = selected && !pause_now && sck_s && !sck_last_reg; // [R06] [R10]
    assign sck_fall = selected && !pause_now && !sck_s && sck_last_reg; // [R07]

    // ----------------------------------------
    // frame state and power
    // ----------------------------------------
    reg seen_rise_reg;

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_armed <= 1'b0;
            o_active <= 1'b0;
            o_standby <= 1'b1;
            o_paused <= 1'b0;
            o_frame_start <= 1'b0;
            o_frame_end <= 1'b0;
            seen_rise_reg <= 1'b0;
        end else begin
            if (sel_fall) begin
                o_armed <= 1'b1; // [R05]
            end
            o_active <= selected || (sel_fall); // [R04]
            o_standby <= sel_n_s && !i_busy; // [R03] [R21]
            o_paused <= pause_now; // [R19]
            o_frame_start <= sel_fall;
            o_frame_end <= sel_rise && o_armed;
            if (!selected) begin
                seen_rise_reg <= 1'b0;
            end else if (sck_rise) begin
                seen_rise_reg <= 1'b1; // [R01]
            end
        end
    end

    // ----------------------------------------
    // receive shifter
    // ----------------------------------------
    reg [7:0] rx_sh_reg;
    reg [7:0] rx_sh_next;
    reg [`SFPI_BIT_CNT_BITS-1:0] rx_cnt_reg;
    reg [`SFPI_BIT_CNT_BITS-1:0] rx_cnt_next;
    reg rx_push_reg;
    reg [7:0] rx_byte_reg;
    wire fifo_in_ready;

    always @* begin
        rx_sh_next = rx_sh_reg;
        rx_cnt_next = rx_cnt_reg;
        case (i_in_width)
            `SFPI_WIDTH_DUAL: begin
                rx_sh_next = {rx_sh_reg[5:0], io_s[1:0]}; // [R22]
                rx_cnt_next = rx_cnt_reg + 4'h2;
            end
            `SFPI_WIDTH_QUAD: begin
                rx_sh_next = {rx_sh_reg[3:0], io_s[3:0]}; // [R15]
                rx_cnt_next = rx_cnt_reg + 4'h4;
            end
            default: begin
                rx_sh_next = {rx_sh_reg[6:0], io_s[0]}; // [R08] [R22]
                rx_cnt_next = rx_cnt_reg + 4'h1;
            end
        endcase
    end

    // a full buffer cannot stall the host clock, so the byte is dropped and flagged
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            rx_sh_reg <= `SFPI_RST_BYTE;
            rx_cnt_reg <= `SFPI_RST_CNT;
            rx_push_reg <= 1'b0;
            rx_byte_reg <= `SFPI_RST_BYTE;
            o_rx_overrun <= 1'b0;
            o_frame_bytes <= {`SFPI_FRAME_CNT_BITS{1'b0}};
            o_page_full <= 1'b0;
        end else begin
            rx_push_reg <= 1'b0;
            if (sel_fall) begin
                o_rx_overrun <= 1'b0;
                o_frame_bytes <= {`SFPI_FRAME_CNT_BITS{1'b0}};
                o_page_full <= 1'b0;
            end
            if (!selected) begin
                rx_cnt_reg <= `SFPI_RST_CNT; // [R10]
            end else if (sck_rise && !i_out_phase) begin
                rx_sh_reg <= rx_sh_next; // [R06]
                if (rx_cnt_next == `SFPI_BYTE_BITS) begin
                    rx_cnt_reg <= `SFPI_RST_CNT;
                    rx_byte_reg <= rx_sh_next;
                    if (fifo_in_ready) begin
                        rx_push_reg <= 1'b1;
                    end else begin
                        o_rx_overrun <= 1'b1;
                    end
                    if (o_frame_bytes != `SFPI_PAGE_BYTES) begin
                        o_frame_bytes <= o_frame_bytes + 1'b1; // [R17]
                    end
                    if (o_frame_bytes == `SFPI_PAGE_BYTES - 1) begin
                        o_page_full <= 1'b1; // [R17]
                    end
                end else begin
                    rx_cnt_reg <= rx_cnt_next;
                end
            end
        end
    end

    sfpi_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_rx_fifo (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_in_valid(rx_push_reg),
        .o_in_ready(fifo_in_ready),
        .i_in_data(rx_byte_reg),
        .o_out_valid(o_rx_valid),
        .i_out_ready(i_rx_ready),
        .o_out_data(o_rx_data)
    );

    // ----------------------------------------
    // transmit shifter
    // ----------------------------------------
    reg [7:0] tx_sh_reg;
    reg [`SFPI_BIT_CNT_BITS-1:0] tx_left_reg;
    reg [2:0] step;
    wire tx_empty;
    wire tx_load;

    assign tx_empty = (tx_left_reg == `SFPI_RST_CNT);
    // load at once when idle, otherwise on the fall that drains the last bits
    assign tx_load = selected && i_out_phase && i_tx_valid && !pause_now &&
        (tx_empty || (sck_fall && seen_rise_reg && tx_left_reg == {1'b0, step}));
    assign o_tx_ready = tx_load;

    always @* begin
        case (i_out_width)
            `SFPI_WIDTH_DUAL: step = 3'h2;
            `SFPI_WIDTH_QUAD: step = 3'h4;
            default: step = 3'h1;
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            tx_sh_reg <= `SFPI_RST_BYTE;
            tx_left_reg <= `SFPI_RST_CNT;
            o_tx_underrun <= 1'b0;
        end else begin
            if (sel_fall) begin
                o_tx_underrun <= 1'b0;
            end
            if (!selected || !i_out_phase) begin
                tx_left_reg <= `SFPI_RST_CNT;
            end else if (tx_load) begin
                tx_sh_reg <= i_tx_data; // [R22]
                tx_left_reg <= `SFPI_BYTE_BITS;
            end else if (sck_fall && seen_rise_reg && !tx_empty) begin
                tx_sh_reg <= tx_sh_reg << step; // [R07]
                tx_left_reg <= tx_left_reg - {1'b0, step};
                if (tx_left_reg == {1'b0, step}) begin
                    o_tx_underrun <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    wire drive_ok;
    assign drive_ok = selected && !pause_now && i_out_phase; // [R02] [R12] [R19]
    assign o_io1_oe = drive_ok; // [R11] [R12]
    assign o_io0_oe = drive_ok && (i_out_width != `SFPI_WIDTH_SINGLE); // [R09] [R10]
    assign o_io2_oe = drive_ok && (i_out_width == `SFPI_WIDTH_QUAD) && i_quad_enable_bit; // [R15]
    assign o_io3_oe = drive_ok && (i_out_width == `SFPI_WIDTH_QUAD) && i_quad_enable_bit;

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_io0 <= 1'b0;
            o_io1 <= 1'b0;
            o_io2 <= 1'b0;
            o_io3 <= 1'b0;
        end else begin
            case (i_out_width)
                `SFPI_WIDTH_DUAL: begin
                    o_io1 <= tx_sh_reg[7]; // [R11]
                    o_io0 <= tx_sh_reg[6]; // [R09]
                    o_io2 <= 1'b0;
                    o_io3 <= 1'b0;
                end
                `SFPI_WIDTH_QUAD: begin
                    o_io3 <= tx_sh_reg[7];
                    o_io2 <= tx_sh_reg[6];
                    o_io1 <= tx_sh_reg[5];
                    o_io0 <= tx_sh_reg[4]; // [R09]
                end
                default: begin
                    o_io1 <= tx_sh_reg[7]; // [R22]
                    o_io0 <= 1'b0;
                    o_io2 <= 1'b0;
                    o_io3 <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // write protection
    // ----------------------------------------
    // region span as an address shift; range code 7 covers the whole array unless the small region bit is set
    reg [4:0] span_shift;
    reg range_all;
    reg [`SFPI_ADDR_BITS:0] span;
    reg [`SFPI_ADDR_BITS:0] top_base;
    wire wp_low;

    assign wp_low = !i_quad_enable_bit && (io_s[2] == `SFPI_WP_ACTIVE); // [R15]

    always @* begin
        range_all = (i_protect_range_bits == `SFPI_RANGE_ALL);
        if (i_small_region_bit) begin
            span_shift = 5'd11 + {2'b00, i_protect_range_bits};
            if (span_shift > `SFPI_SMALL_MAX_SHIFT) begin
                span_shift = `SFPI_SMALL_MAX_SHIFT;
            end
        end else begin
            span_shift = 5'd15 + {2'b00, i_protect_range_bits};
        end
        span = {{`SFPI_ADDR_BITS{1'b0}}, 1'b1} << span_shift;
        top_base = ({1'b1, {`SFPI_ADDR_BITS{1'b0}}}) - span;
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_status_write_locked <= 1'b0;
            o_addr_in_range <= 1'b0;
            o_addr_hw_locked <= 1'b0;
        end else begin
            o_status_write_locked <= wp_low && i_status_protect_bit; // [R13]
            if (i_protect_range_bits == `SFPI_RANGE_NONE) begin
                o_addr_in_range <= 1'b0;
            end else if (range_all && !i_small_region_bit) begin
                o_addr_in_range <= 1'b1; // [R14]
            end else if (i_top_bottom_select) begin
                o_addr_in_range <= ({1'b0, i_probe_addr} < span); // [R14]
            end else begin
                o_addr_in_range <= ({1'b0, i_probe_addr} >= top_base); // [R14]
            end
            o_addr_hw_locked <= o_addr_in_range && wp_low && i_status_protect_bit; // [R14]
        end
    end

    // ----------------------------------------
    // erase unit alignment
    // ----------------------------------------
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_erase_base <= {`SFPI_ADDR_BITS{1'b0}};
        end else begin
            case (i_erase_kind)
                `SFPI_ERASE_4K: o_erase_base <= (i_probe_addr >> `SFPI_SHIFT_4K) << `SFPI_SHIFT_4K;
                `SFPI_ERASE_32K: o_erase_base <= (i_probe_addr >> `SFPI_SHIFT_32K) << `SFPI_SHIFT_32K;
                `SFPI_ERASE_64K: o_erase_base <= (i_probe_addr >> `SFPI_SHIFT_64K) << `SFPI_SHIFT_64K; // [R18]
                default: o_erase_base <= {`SFPI_ADDR_BITS{1'b0}}; // [R16] [R18]
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- sfpi_consts.vh ----
`ifndef SFPI_CONSTS_VH
`define SFPI_CONSTS_VH

// ----------------------------------------
// pin activity levels
// ----------------------------------------
`define SFPI_SEL_ACTIVE 1'b0
`define SFPI_PAUSE_ACTIVE 1'b0
`define SFPI_WP_ACTIVE 1'b0

// ----------------------------------------
// lane width codes for shifting
// ----------------------------------------
`define SFPI_WIDTH_SINGLE 2'h0
`define SFPI_WIDTH_DUAL 2'h1
`define SFPI_WIDTH_QUAD 2'h2

// ----------------------------------------
// array geometry
// ----------------------------------------
`define SFPI_ADDR_BITS 23
`define SFPI_PAGE_COUNT 32768
`define SFPI_PAGE_BYTES 256
`define SFPI_BYTE_BITS 4'h8
`define SFPI_BIT_CNT_BITS 4
`define SFPI_FRAME_CNT_BITS 9

// ----------------------------------------
// erase granularity codes and sizes (address bits)
// ----------------------------------------
`define SFPI_ERASE_4K 2'h0
`define SFPI_ERASE_32K 2'h1
`define SFPI_ERASE_64K 2'h2
`define SFPI_ERASE_CHIP 2'h3
`define SFPI_SHIFT_4K 12
`define SFPI_SHIFT_32K 15
`define SFPI_SHIFT_64K 16

// ----------------------------------------
// protect range encoding
// ----------------------------------------
`define SFPI_RANGE_NONE 3'h0
`define SFPI_RANGE_ALL 3'h7
`define SFPI_SMALL_MAX_SHIFT 5'h0F

// ----------------------------------------
// buffering and reset values
// ----------------------------------------
`define SFPI_FIFO_DEPTH 4
`define SFPI_RST_BYTE 8'h00
`define SFPI_RST_CNT 4'h0

`endif

// ---- sfpi_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

module sfpi_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);

    // ----------------------------------------
    // flop storage, index pointers
    // ----------------------------------------
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;

    assign o_in_ready = (cnt_reg != DEPTH[AW:0]);
    assign o_out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign o_out_data = mem_reg[rd_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @(posedge i_clock) begin
        if (push) begin
            mem_reg[wr_reg] <= i_in_data;
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- sfpi_pin_interface_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sfpi_consts.vh"

module sfpi_pin_interface_checker (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_select_n,
    input wire logic i_io3,
    input wire logic [1:0] i_out_width,
    input wire logic i_out_phase,
    input wire logic i_rx_ready,
    input wire logic i_busy,
    input wire logic i_quad_enable_bit,
    input wire logic o_io0_oe,
    input wire logic o_io1_oe,
    input wire logic o_io2_oe,
    input wire logic o_io3_oe,
    input wire logic o_rx_valid,
    input wire logic [7:0] o_rx_data,
    input wire logic o_active,
    input wire logic o_standby,
    input wire logic o_armed,
    input wire logic o_frame_start,
    input wire logic o_frame_end,
    input wire logic [`SFPI_FRAME_CNT_BITS-1:0] o_frame_bytes,
    input wire logic o_page_full,
    input wire logic o_status_write_locked,
    input wire logic o_addr_in_range,
    input wire logic o_addr_hw_locked
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // ----------------------------------------
    // select steps; five samples cover the pin synchroniser
    // ----------------------------------------
    sequence sel_fall;
        $fell(i_select_n) ##1 !i_select_n [*4];
    endsequence
    sequence desel_held;
        i_select_n [*5];
    endsequence

    a_desel_release: assert property (desel_held |->
        !(o_io0_oe | o_io1_oe | o_io2_oe | o_io3_oe)) else $error("oe while deselected");
    a_select_active: assert property (sel_fall |-> o_active)
        else $error("select fall not active");
    a_standby_idle: assert property ((i_select_n && !i_busy) [*5] |-> o_standby)
        else $error("no standby");
    a_busy_no_standby: assert property (i_busy [*2] |-> !o_standby)
        else $error("standby while busy");
    a_standby_excl: assert property (o_standby |-> !o_active)
        else $error("standby and active");
    a_frame_pulse: assert property (o_frame_start |=> !o_frame_start)
        else $error("frame start too long");
    a_frame_end: assert property ($rose(i_select_n) |-> ##3 o_frame_end)
        else $error("no frame end");
    a_unarmed_quiet: assert property (!o_armed |-> !o_rx_valid)
        else $error("data before arming");
    a_armed_sticky: assert property (o_armed |=> o_armed)
        else $error("armed dropped");
    a_io1_phase: assert property (o_io1_oe |-> i_out_phase)
        else $error("io1 driven outside read");
    a_io0_width: assert property (o_io0_oe |->
        o_io1_oe && i_out_width != `SFPI_WIDTH_SINGLE) else $error("io0 driven in single");
    a_quad_oe: assert property (o_io2_oe |-> i_quad_enable_bit && o_io0_oe)
        else $error("io2 driven without quad");
    a_pause_quiet: assert property ((!i_io3 && !i_quad_enable_bit && !i_select_n) [*4]
        |-> !o_io1_oe) else $error("io1 driven in pause");
    a_page_count: assert property (o_page_full |-> o_frame_bytes == 9'h100)
        else $error("page full early");
    a_lock_range: assert property (o_addr_hw_locked |-> $past(o_addr_in_range))
        else $error("lock outside range");
    a_qe_unlock: assert property (i_quad_enable_bit [*3] |->
        !o_addr_hw_locked && !o_status_write_locked) else $error("lock with quad on");
    a_rx_hold: assert property (o_rx_valid && !i_rx_ready |=>
        o_rx_valid && $stable(o_rx_data)) else $error("rx byte moved unpopped");
endmodule

`default_nettype wire

// ---- sfpi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module sfpi_host_model (
    input wire logic i_io0_w,
    input wire logic i_io1_w,
    output logic o_select_n,
    output logic o_sck,
    output logic o_io0,
    output logic o_io3
);
    // ----------------------------------------
    // host controller, mode 0, 80 ns clock
    // ----------------------------------------
    initial begin
        o_select_n = 1'b1;
        o_sck = 1'b0;
        o_io0 = 1'b0;
        o_io3 = 1'b1;
    end

    task automatic sel(input logic v);
        #100;
        o_select_n = v;
        #100;
    endtask

    // dual reads: io0 belongs to the device, so ours just toggles
    task automatic xfer(input logic [7:0] tx, input int w, output logic [7:0] rx);
        int k;
        rx = 8'h00;
        for (k = 0; k < 8 / w; k++) begin
            o_io0 = (w == 1) ? tx[7 - k] : ~o_io0;
            #40 o_sck = 1'b1;
            rx = (w == 1) ? {rx[6:0], i_io1_w} : {rx[5:0], i_io1_w, i_io0_w};
            #40 o_sck = 1'b0;
        end
    endtask

    task automatic hold(input int n);
        o_io3 = 1'b0;
        repeat (n) begin
            #40 o_sck = 1'b1;
            o_io0 = ~o_io0;
            #40 o_sck = 1'b0;
        end
        #40 o_io3 = 1'b1;
    endtask
endmodule

`default_nettype wire

// ---- sfpi_pin_interface_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sfpi_consts.vh"

module sfpi_pin_interface_tb;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [1:0] i_in_width = 2'h0, i_out_width = 2'h0, i_erase_kind = 2'h0;
    logic i_out_phase = 1'b0, i_tx_valid = 1'b0, i_rx_ready = 1'b0, i_busy = 1'b0;
    logic i_quad_enable_bit = 1'b0, i_status_protect_bit = 1'b0, wp_n = 1'b1;
    logic i_small_region_bit = 1'b0, i_top_bottom_select = 1'b0, flip = 1'b0;
    logic [2:0] i_protect_range_bits = 3'h0;
    logic [7:0] i_tx_data = 8'h00;
    logic [22:0] i_probe_addr = 23'h0;
    wire i_select_n, i_sck, h_io0, h_io3, i_io0, i_io1, i_io2, i_io3;
    wire o_io0, o_io1, o_io2, o_io3, o_io0_oe, o_io1_oe, o_io2_oe, o_io3_oe;
    wire o_tx_ready, o_rx_valid, o_rx_overrun, o_tx_underrun, o_active, o_standby;
    wire o_armed, o_paused, o_frame_start, o_frame_end, o_page_full;
    wire o_status_write_locked, o_addr_in_range, o_addr_hw_locked;
    wire [7:0] o_rx_data;
    wire [8:0] o_frame_bytes;
    wire [22:0] o_erase_base;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [7:0] exp_q[$];

    always #2.5 i_clock = ~i_clock;
    // undriven io1 wanders, or copies the host io0 in dual input, so a stale value never passes
    always @(negedge i_clock) flip <= ~flip;
    assign i_io0 = o_io0_oe ? o_io0 : h_io0;
    assign i_io1 = o_io1_oe ? o_io1 : (i_in_width[0] ? h_io0 : flip);
    assign i_io2 = o_io2_oe ? o_io2 : wp_n;
    assign i_io3 = o_io3_oe ? o_io3 : h_io3;

    sfpi_pin_interface i_dut (.*);
    sfpi_host_model i_host (.i_io0_w(i_io0), .i_io1_w(i_io1), .o_select_n(i_select_n),
                            .o_sck(i_sck), .o_io0(h_io0), .o_io3(h_io3));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge i_clock) begin
        if (i_rst_n && o_rx_valid === 1'b1 && i_rx_ready) begin
            if (exp_q.size() == 0) check(o_rx_data, 32'h1FF);
            else check(o_rx_data, exp_q.pop_front());
        end
    end

    function automatic logic in_rng(input logic [22:0] a, input logic s, input logic t,
                                    input logic [2:0] bp);
        int sh;
        sh = s ? 11 + bp : (bp == 3'h7 ? 23 : 15 + bp);
        if (s && sh > 15) sh = 15;
        if (bp == 3'h0) return 1'b0;
        return t ? (a < (24'h1 << sh)) : ({1'b0, a} >= 24'h800000 - (24'h1 << sh));
    endfunction

    task automatic send(input logic [7:0] b, input logic keep);
        logic [7:0] r;
        if (keep) exp_q.push_back(b);
        i_host.xfer(b, 1, r);
    endtask

    task automatic read(input logic [1:0] w);
        logic [7:0] b, r;
        int n;
        b = $urandom;
        n = 0;
        i_host.sel(1'b0);
        i_out_width = w;
        i_out_phase = 1'b1;
        i_tx_data = b;
        i_tx_valid = 1'b1;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_tx_ready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        @(negedge i_clock);
        i_tx_valid = 1'b0;
        i_host.xfer(8'h00, (w == `SFPI_WIDTH_DUAL) ? 2 : 1, r);
        check(r, b);
        i_host.sel(1'b1);
        check(o_tx_underrun, 1);
        i_out_phase = 1'b0;
    endtask

    initial begin
        #400000;
        error_cnt++;
        finish_test();
    end

    initial begin
        logic [7:0] r;
        logic [22:0] eb;
        logic lk, ir;
        int k, sh;
        void'($urandom(32'hA9300019));
        repeat (4) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clock);
        check(o_standby, 1);
        i_host.xfer(8'hA5, 1, r);
        check(o_armed, 0);
        // ----------------------------------------
        // write frame: fill the fifo, lose one, drain, pause
        // ----------------------------------------
        i_host.sel(1'b0);
        check(o_active, 1);
        for (k = 0; k < 5; k++) send($urandom, k < 4);
        check(o_rx_overrun, 1);
        check(o_frame_bytes, 5);
        repeat (40) @(negedge i_clock) i_rx_ready = $urandom;
        i_rx_ready = 1'b1;
        check(exp_q.size(), 0);
        fork i_host.hold(8); #400 check(o_paused, 1); join
        send(8'h3C, 1'b1);
        check(o_frame_bytes, 6);
        i_in_width = `SFPI_WIDTH_DUAL;
        exp_q.push_back(8'hF0);
        exp_q.push_back(8'h33);
        i_host.xfer(8'hC5, 1, r);
        i_in_width = 2'h0;
        i_host.sel(1'b1);
        i_busy = 1'b1;
        repeat (6) @(negedge i_clock);
        check(o_standby, 0);
        i_busy = 1'b0;
        repeat (6) @(negedge i_clock);
        check(o_standby, 1);
        read(`SFPI_WIDTH_SINGLE);
        read(`SFPI_WIDTH_DUAL);
        // one whole page, then one byte past it
        i_host.sel(1'b0);
        for (k = 0; k < 257; k++) begin
            send($urandom, 1'b1);
            if (k == 254) check(o_page_full, 0);
        end
        check(o_page_full, 1);
        check(o_frame_bytes, 9'h100);
        i_host.sel(1'b1);
        for (k = 0; k < 16; k++) begin
            {wp_n, i_status_protect_bit, i_quad_enable_bit, i_small_region_bit,
             i_top_bottom_select, i_protect_range_bits} = $urandom;
            i_probe_addr = $urandom >> (k[0] ? 12 : 9);
            i_erase_kind = k[1:0];
            repeat (6) @(negedge i_clock);
            lk = !wp_n && i_status_protect_bit && !i_quad_enable_bit;
            ir = in_rng(i_probe_addr, i_small_region_bit, i_top_bottom_select,
                        i_protect_range_bits);
            sh = (k % 4 == 0) ? `SFPI_SHIFT_4K : (k % 4 == 1) ? `SFPI_SHIFT_32K : `SFPI_SHIFT_64K;
            eb = (k % 4 == 3) ? 23'h0 : (i_probe_addr >> sh) << sh;
            check(o_status_write_locked, lk);
            check(o_addr_in_range, ir);
            check(o_addr_hw_locked, ir && lk);
            check(o_erase_base, eb);
        end
        check(exp_q.size(), 0);
        finish_test();
    end
endmodule

bind sfpi_pin_interface sfpi_pin_interface_checker i_chk (.*);

`default_nettype wire
